//--- verilog/aakd_consts.svh
// constants for the aes based authentication and key derivation engine
`ifndef AAKD_CONSTS_SVH
`define AAKD_CONSTS_SVH
`define AAKD_LAST_ROUND 4'hA
`define AAKD_FIRST_ROUND 4'h1
`define AAKD_RCON_INIT 8'h01
`define AAKD_POLY 8'h1B
`define AAKD_AFFINE 8'h63
`define AAKD_TAG_HI 127
`define AAKD_TAG_LO 96
`define AAKD_FLIP_BIT 128'h00000000000000000000000000000001
`define AAKD_ZERO128 128'h00000000000000000000000000000000
`define AAKD_ZERO32 32'h00000000
`endif

//--- verilog/aakd_pkg.sv
// types for the aes based authentication and key derivation engine
`default_nettype none
package aakd_pkg;
    // gray order along idle -> first pass -> second pass
    typedef enum logic [1:0] {
        AAKD_IDLE = 2'h0,
        AAKD_PASS1 = 2'h1,
        AAKD_PASS2 = 2'h3
    } aakd_state_t;
endpackage
`default_nettype wire

//--- verilog/aakd_engine.sv
// aes-128 based session key, tag and cipher key derivation engine
`timescale 1ns/1ps
`default_nettype none
`include "aakd_consts.svh"

// How it works
// - secret up to 128, publics up to 64
// - session key mode or tag mode
// - key is secret, low unused bits zeroed
// - plaintext is two zero padded halves
// - first encryption of plaintext under key
// - session mode encrypts ciphertext again, same key
// - session key is second ciphertext unchanged
// - tag is first 32 ciphertext bits
// - tag mode flips bit 127 before second pass
// - cipher key is first t bits
// - bit 0 is the most significant bit
module aakd_engine (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic tag_mode,
    input wire logic [127:0] secret_input,
    input wire logic [7:0] secret_len,
    input wire logic [63:0] first_public_input,
    input wire logic [6:0] first_public_len,
    input wire logic [63:0] second_public_input,
    input wire logic [6:0] second_public_len,
    input wire logic [7:0] cipher_key_len,
    output logic busy,
    output logic done,
    output logic [127:0] session_key,
    output logic [31:0] auth_tag,
    output logic [127:0] derived_cipher_key
);
    aakd_pkg::aakd_state_t state, next_state;
    logic [127:0] blk, next_blk;
    logic [127:0] rkey, next_rkey;
    logic [127:0] key0, next_key0;
    logic [127:0] w_keep, next_w_keep;
    logic [127:0] ck_mask, next_ck_mask;
    logic [7:0] rcon, next_rcon;
    logic [3:0] round, next_round;
    logic mode, next_mode;
    logic next_busy, next_done;
    logic [127:0] next_session_key, next_derived_cipher_key;
    logic [31:0] next_auth_tag;
    logic [127:0] round_out, round_key;
    logic accept;

    // top len bits set; lengths past the maximum saturate to all ones
    function automatic logic [127:0] mask128(input logic [7:0] len);
        mask128 = ~({128{1'b1}} >> len);
    endfunction

    function automatic logic [63:0] mask64(input logic [6:0] len);
        mask64 = ~({64{1'b1}} >> len);
    endfunction

    function automatic logic [7:0] xt(input logic [7:0] a);
        xt = {a[6:0], 1'b0} ^ (a[7] ? `AAKD_POLY : 8'h00);
    endfunction

    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                p = p ^ x;
            end
            x = xt(x);
        end
        gmul = p;
    endfunction

    // s-box computed as a^254 then affine map; no table, more logic depth
    function automatic logic [7:0] sbox(input logic [7:0] a);
        logic [7:0] p;
        logic [7:0] r;
        p = a;
        r = 8'h01;
        for (int i = 0; i < 7; i++) begin
            p = gmul(p, p);
            r = gmul(r, p);
        end
        sbox = r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]}
            ^ {r[3:0], r[7:4]} ^ `AAKD_AFFINE;
    endfunction

    function automatic logic [31:0] sub_word(input logic [31:0] w);
        for (int i = 0; i < 4; i++) begin
            sub_word[8*i +: 8] = sbox(w[8*i +: 8]);
        end
    endfunction

    // byte j of the block holds sequence bits 8j..8j+7, bit 0 at the msb
    logic [7:0] sb [16];
    logic [7:0] sr [16];
    genvar gj;
    generate
        for (gj = 0; gj < 16; gj++) begin : g_bytes
            assign sb[gj] = sbox(blk[127-8*gj -: 8]);
            // shift rows: row r of column c comes from column c+r
            assign sr[gj] = sb[(gj % 4) + 4 * (((gj / 4) + (gj % 4)) % 4)];
            logic [7:0] a0, a1, a2, a3, mc;
            assign a0 = sr[4*(gj/4) + (gj%4)];
            assign a1 = sr[4*(gj/4) + ((gj+1)%4)];
            assign a2 = sr[4*(gj/4) + ((gj+2)%4)];
            assign a3 = sr[4*(gj/4) + ((gj+3)%4)];
            assign mc = xt(a0) ^ xt(a1) ^ a1 ^ a2 ^ a3;
            // last round skips mix columns
            assign round_out[127-8*gj -: 8] = ((round == `AAKD_LAST_ROUND) ? sr[gj] : mc)
                ^ round_key[127-8*gj -: 8];
        end
    endgenerate

    // on-the-fly key schedule, one round key per cycle
    always_comb begin
        logic [31:0] t;
        logic [31:0] n0, n1, n2, n3;
        t = 32'h00000000;
        t = sub_word({rkey[23:0], rkey[31:24]}) ^ {rcon, 24'h000000};
        n0 = rkey[127:96] ^ t;
        n1 = rkey[95:64] ^ n0;
        n2 = rkey[63:32] ^ n1;
        n3 = rkey[31:0] ^ n2;
        round_key = {n0, n1, n2, n3};
    end

    assign accept = start && (state == aakd_pkg::AAKD_IDLE);

    // sequencing of both passes and output capture
    always_comb begin
        logic [127:0] k;
        logic [127:0] p;
        k = secret_input & mask128(secret_len);
        p = {first_public_input & mask64(first_public_len),
            second_public_input & mask64(second_public_len)};
        next_state = state;
        next_blk = blk;
        next_rkey = rkey;
        next_key0 = key0;
        next_w_keep = w_keep;
        next_ck_mask = ck_mask;
        next_rcon = rcon;
        next_round = round;
        next_mode = mode;
        next_busy = busy;
        next_done = done;
        next_session_key = session_key;
        next_auth_tag = auth_tag;
        next_derived_cipher_key = derived_cipher_key;
        case (state)
            aakd_pkg::AAKD_IDLE: begin
                // start while busy never reaches here, so it is ignored
                if (accept) begin
                    next_state = aakd_pkg::AAKD_PASS1;
                    next_key0 = k;
                    next_rkey = k;
                    next_blk = p ^ k;
                    next_round = `AAKD_FIRST_ROUND;
                    next_rcon = `AAKD_RCON_INIT;
                    next_mode = tag_mode;
                    next_ck_mask = mask128(cipher_key_len);
                    next_busy = 1'b1;
                    next_done = 1'b0;
                end
            end
            aakd_pkg::AAKD_PASS1, aakd_pkg::AAKD_PASS2: begin
                next_blk = round_out;
                next_rkey = round_key;
                next_rcon = xt(rcon);
                next_round = round + 4'h1;
                if (round == `AAKD_LAST_ROUND) begin
                    next_rkey = key0;
                    next_round = `AAKD_FIRST_ROUND;
                    next_rcon = `AAKD_RCON_INIT;
                    if (state == aakd_pkg::AAKD_PASS1) begin
                        // second pass reuses the same key
                        next_state = aakd_pkg::AAKD_PASS2;
                        next_w_keep = round_out;
                        next_blk = (mode ? (round_out ^ `AAKD_FLIP_BIT) : round_out) ^ key0;
                    end else begin
                        next_state = aakd_pkg::AAKD_IDLE;
                        next_busy = 1'b0;
                        next_done = 1'b1;
                        if (mode) begin
                            next_session_key = `AAKD_ZERO128;
                            next_auth_tag = w_keep[`AAKD_TAG_HI:`AAKD_TAG_LO];
                            next_derived_cipher_key = round_out & ck_mask;
                        end else begin
                            next_session_key = round_out;
                            next_auth_tag = `AAKD_ZERO32;
                            next_derived_cipher_key = `AAKD_ZERO128;
                        end
                    end
                end
            end
            default: begin
                next_state = aakd_pkg::AAKD_IDLE;
                next_busy = 1'b0;
            end
        endcase
    end

    // registers only; outputs stay put from done until the next start
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= aakd_pkg::AAKD_IDLE;
            blk <= `AAKD_ZERO128;
            rkey <= `AAKD_ZERO128;
            key0 <= `AAKD_ZERO128;
            w_keep <= `AAKD_ZERO128;
            ck_mask <= `AAKD_ZERO128;
            rcon <= `AAKD_RCON_INIT;
            round <= `AAKD_FIRST_ROUND;
            mode <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            session_key <= `AAKD_ZERO128;
            auth_tag <= `AAKD_ZERO32;
            derived_cipher_key <= `AAKD_ZERO128;
        end else begin
            state <= next_state;
            blk <= next_blk;
            rkey <= next_rkey;
            key0 <= next_key0;
            w_keep <= next_w_keep;
            ck_mask <= next_ck_mask;
            rcon <= next_rcon;
            round <= next_round;
            mode <= next_mode;
            busy <= next_busy;
            done <= next_done;
            session_key <= next_session_key;
            auth_tag <= next_auth_tag;
            derived_cipher_key <= next_derived_cipher_key;
        end
    end

    // checks
    sequence s_accept;
        start && !busy;
    endsequence
    sequence s_finish;
        ##20 (done && !busy);
    endsequence

    property p_latency;
        @(posedge mclk) disable iff (!arst_n) s_accept |-> ##1 (busy && !done) ##0 s_finish;
    endproperty
    a_latency: assert property (p_latency) else $error("done not 20 cycles after start");
    // every result output must stand while done is up and no new start comes
    property p_hold;
        @(posedge mclk) disable iff (!arst_n)
            done && !start |=> done && $stable(session_key) && $stable(derived_cipher_key)
                && $stable(auth_tag);
    endproperty
    a_hold: assert property (p_hold) else $error("outputs moved while done");
    property p_ignore;
        @(posedge mclk) disable iff (!arst_n) busy && start |=> $stable(key0) && $stable(mode);
    endproperty
    a_ignore: assert property (p_ignore) else $error("start taken while busy");
    property p_key;
        @(posedge mclk) disable iff (!arst_n)
            s_accept |=> key0 == ($past(secret_input) & mask128($past(secret_len)));
    endproperty
    a_key: assert property (p_key) else $error("key not masked secret");
    property p_plain;
        @(posedge mclk) disable iff (!arst_n)
            s_accept |=> (blk ^ key0) == {$past(first_public_input) & mask64($past(first_public_len)),
                $past(second_public_input) & mask64($past(second_public_len))};
    endproperty
    a_plain: assert property (p_plain) else $error("plaintext layout wrong");
    property p_flip;
        @(posedge mclk) disable iff (!arst_n)
            state == aakd_pkg::AAKD_PASS1 ##1 state == aakd_pkg::AAKD_PASS2 |->
            (blk ^ key0) == (mode ? (w_keep ^ `AAKD_FLIP_BIT) : w_keep);
    endproperty
    a_flip: assert property (p_flip) else $error("second plaintext wrong");
    property p_tag;
        @(posedge mclk) disable iff (!arst_n)
            $rose(done) && mode |-> auth_tag == w_keep[`AAKD_TAG_HI:`AAKD_TAG_LO] && session_key == 0;
    endproperty
    a_tag: assert property (p_tag) else $error("tag not first ciphertext word");
    property p_trunc;
        @(posedge mclk) disable iff (!arst_n)
            $rose(done) |-> (derived_cipher_key & ~ck_mask) == 0 && (mode || derived_cipher_key == 0);
    endproperty
    a_trunc: assert property (p_trunc) else $error("cipher key not truncated");
    property p_session;
        @(posedge mclk) disable iff (!arst_n)
            $rose(done) && !mode |-> auth_tag == 0 && session_key == $past(round_out);
    endproperty
    a_session: assert property (p_session) else $error("session key not second ciphertext");
endmodule
`default_nettype wire

//--- bench/aakd_host.sv
// host side model: presents inputs with a start pulse, then waits for done
`timescale 1ns/1ps
`default_nettype none
module aakd_host (
    input wire logic mclk,
    input wire logic done,
    output logic start,
    output logic tag_mode,
    output logic [127:0] secret_input,
    output logic [7:0] secret_len,
    output logic [63:0] first_public_input,
    output logic [6:0] first_public_len,
    output logic [63:0] second_public_input,
    output logic [6:0] second_public_len,
    output logic [7:0] cipher_key_len
);
    // quiet host at time zero
    initial begin
        {start, tag_mode, secret_input, secret_len, first_public_input} = '0;
        {first_public_len, second_public_input, second_public_len, cipher_key_len} = '0;
    end

    // optional idle gap gives both prompt and slow hosts
    task automatic launch(input logic mode, input logic [127:0] d1, input logic [7:0] m,
        input logic [63:0] d2, input logic [6:0] n, input logic [63:0] d3,
        input logic [6:0] r, input logic [7:0] t, input int gap);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        start <= 1'b1;
        tag_mode <= mode;
        {secret_input, secret_len} <= {d1, m};
        {first_public_input, first_public_len} <= {d2, n};
        {second_public_input, second_public_len} <= {d3, r};
        cipher_key_len <= t;
        @(posedge mclk);
        start <= 1'b0;
        // data is scrambled once taken, since the engine must not look again
        secret_input <= ~secret_input;
        {first_public_input, second_public_input} <= ~{first_public_input, second_public_input};
    endtask

    // bounded wait; cnt counts edges after the call
    task automatic wait_done(output int cnt);
        cnt = 0;
        while (cnt < 40) begin
            @(posedge mclk);
            cnt++;
            #1;
            if (done === 1'b1) break;
        end
    endtask
endmodule
`default_nettype wire

//--- bench/aakd_engine_tb_top.sv
// self-checking testbench for the derivation engine
`timescale 1ns/1ps
`default_nettype none
module aakd_engine_tb_top;
    logic mclk, arst_n, start, tag_mode, busy, done;
    logic [127:0] secret_input, session_key, derived_cipher_key;
    logic [7:0] secret_len, cipher_key_len;
    logic [63:0] first_public_input, second_public_input;
    logic [6:0] first_public_len, second_public_len;
    logic [31:0] auth_tag;
    int mismatches = 0;
    int total_checks = 0;
    // known answers; low bits past each length carry junk that must be masked
    logic [127:0] v_d1 [3] = '{128'h42025EE339743AF647B5778025E9B66D,
        128'hBCD32DB021D5D00993428051F1CC37FF, 128'h631C95B179BB52EBBA6B28EF5FFFFFFF};
    logic [7:0] v_m [3] = '{8'h80, 8'h78, 8'h63};
    logic [63:0] v_d2 [3] = '{64'hA0F3624E949640A0, 64'h10439453B0B8733F, 64'h1E171CB2AF7FFFFF};
    logic [6:0] v_n [3] = '{7'h40, 7'h3C, 7'h2B};
    logic [63:0] v_d3 [3] = '{64'h17DA4751F5B2B180, 64'hAFE2C12D7DC18FAB, 64'h6C0C285011136ABF};
    logic [6:0] v_r [3] = '{7'h40, 7'h38, 7'h3D};
    logic [127:0] v_e [3] = '{128'h294016C034CD1A5576081826366A7E4A,
        128'hCE6AAEDBE96CDCE78650116CDD109180, 128'h312AD124B1F0541C93D286FCD618451E};
    logic [7:0] t_list [4] = '{8'h25, 8'h00, 8'h7F, 8'hC8};

    aakd_host host (.mclk(mclk), .done(done), .start(start), .tag_mode(tag_mode),
        .secret_input(secret_input), .secret_len(secret_len),
        .first_public_input(first_public_input), .first_public_len(first_public_len),
        .second_public_input(second_public_input), .second_public_len(second_public_len),
        .cipher_key_len(cipher_key_len));
    aakd_engine dut (.mclk(mclk), .arst_n(arst_n), .start(start), .tag_mode(tag_mode),
        .secret_input(secret_input), .secret_len(secret_len),
        .first_public_input(first_public_input), .first_public_len(first_public_len),
        .second_public_input(second_public_input), .second_public_len(second_public_len),
        .cipher_key_len(cipher_key_len), .busy(busy), .done(done), .session_key(session_key),
        .auth_tag(auth_tag), .derived_cipher_key(derived_cipher_key));

    // 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("counts: %0d checks, %0d mismatches", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a hung engine ends the run here
    task automatic finish_op(input int exp_cnt);
        int cnt;
        host.wait_done(cnt);
        check("done latency", exp_cnt, cnt);
        check("busy at done", 0, busy);
        if (cnt >= 40) begin
            complete_run();
        end
    endtask

    task automatic check_idle_zero(input string when);
        check({when, " busy"}, 0, busy);
        check({when, " done"}, 0, done);
        check({when, " outputs"}, 0, session_key | derived_cipher_key | auth_tag);
    endtask

    task automatic test_session();
        for (int i = 0; i < 3; i++) begin
            host.launch(1'b0, v_d1[i], v_m[i], v_d2[i], v_n[i], v_d3[i], v_r[i], 8'h80, i);
            #1;
            check("busy after accept", 1, busy);
            check("done after accept", 0, done);
            finish_op(20);
            check("session key", v_e[i], session_key);
            check("other outputs", 0, auth_tag | derived_cipher_key);
        end
        $display("test session finished");
    endtask

    task automatic test_tag();
        logic [127:0] full;
        host.launch(1'b1, v_d1[0], 8'h80, v_d2[0], 7'h40, v_d3[0], 7'h40, 8'h80, 0);
        finish_op(20);
        full = derived_cipher_key;
        check("flipped block used", 1, full !== v_e[0]);
        for (int k = 0; k < 4; k++) begin
            host.launch(1'b1, v_d1[0], 8'h80, v_d2[0], 7'h40, v_d3[0], 7'h40, t_list[k], 1);
            finish_op(20);
            check("tag", 32'hFAA865E7, auth_tag);
            check("cipher key", full & ~({128{1'b1}} >> t_list[k]), derived_cipher_key);
            check("session key in tag mode", 0, session_key);
        end
        $display("test tag finished");
    endtask

    // a start during a run is dropped and results then stand
    task automatic test_ignore_hold();
        host.launch(1'b0, v_d1[1], v_m[1], v_d2[1], v_n[1], v_d3[1], v_r[1], 8'h80, 0);
        repeat (5) @(posedge mclk);
        host.launch(1'b1, v_d1[0], 8'h80, v_d2[0], 7'h40, v_d3[0], 7'h40, 8'h80, 0);
        finish_op(13);
        check("key after ignored start", v_e[1], session_key);
        repeat (6) @(posedge mclk);
        #1;
        check("done held", 1, done);
        check("key held", v_e[1], session_key);
        $display("test ignore and hold finished");
    endtask

    task automatic test_reset_mid();
        host.launch(1'b0, v_d1[2], v_m[2], v_d2[2], v_n[2], v_d3[2], v_r[2], 8'h80, 0);
        repeat (3) @(posedge mclk);
        arst_n <= 1'b0;
        #1;
        check_idle_zero("mid reset");
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        host.launch(1'b0, v_d1[2], v_m[2], v_d2[2], v_n[2], v_d3[2], v_r[2], 8'h80, 0);
        finish_op(20);
        check("key after reset", v_e[2], session_key);
        $display("test reset finished");
    endtask

    // main sequence
    initial begin
        arst_n = 1'b0;
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        #1;
        check_idle_zero("after reset");
        test_session();
        test_tag();
        test_ignore_hold();
        test_reset_mid();
        complete_run();
    end
endmodule
`default_nettype wire
